/* File: include/scl_params.svh */
// Constants of the strap status and configuration lock block
// Behaviour
// - South bit 0 shows ROM width strap
// - South bit 1 shows RTC enable strap
// - South bit 2 shows keyboard controller strap
// - South bit 3 shows clock ratio strap
// - South bit 7 reads inverted voltage strap
// - South bits 6..4 hold fixed version
// - South register index 01h, read-only, 0Fh
// - North bit 0 shows clock ratio strap
// - North bit 1 shows cache select strap
// - North bit 2 shows parity pin strap
// - North bit 3: 1 for 5V
// - North bits 7..4 hold fixed version
// - North register index 02h, read-only, 0Fh
// - Lock register index 03h, resets 00h
// - C5h unlocks, any other value locks
// - Index at port 22h, data 23h
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH

// I/O ports of the index/data pair
`define SCL_PORT_INDEX 16'h0022
`define SCL_PORT_DATA  16'h0023

// Register indices
`define SCL_IDX_SOUTH 8'h01
`define SCL_IDX_NORTH 8'h02
`define SCL_IDX_LOCK  8'h03

// Lock values and read defaults
`define SCL_UNLOCK_KEY 8'hC5
`define SCL_LOCK_RST   8'h00
`define SCL_INDEX_RST  8'h00
`define SCL_FLOAT_DATA 8'hFF

// Strap pin levels assumed before capture (all pulled up)
`define SCL_SOUTH_PIN_RST 5'h1F
`define SCL_NORTH_PIN_RST 4'hF

// South register field positions
`define SCL_S_ROM  0
`define SCL_S_RTC  1
`define SCL_S_KBD  2
`define SCL_S_CLK  3
`define SCL_S_VER  4
`define SCL_S_VOLT 7

// North register field positions
`define SCL_N_CLK   0
`define SCL_N_CACHE 1
`define SCL_N_PERR  2
`define SCL_N_VOLT  3
`define SCL_N_VER   4

`endif

/* File: include/scl_pkg.sv */
// Types of the strap status and configuration lock block
package scl_pkg;

   // South chip strap pin levels
   typedef struct packed {
      logic cpu_voltage_strap;
      logic clock_ratio_strap;
      logic kbd_ctrl_enable_strap;
      logic rtc_enable_strap;
      logic rom_width_strap;
   } scl_south_pins_t;

   // North chip strap pin levels
   typedef struct packed {
      logic north_voltage_strap;
      logic parity_error_pin_strap;
      logic cache_select_strap;
      logic clock_ratio_strap;
   } scl_north_pins_t;

   // One host I/O cycle
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } scl_io_req_t;

endpackage

/* File: rtl/scl_strap_latch.sv */
// Captures strap levels once after power-on reset and holds them
module scl_strap_latch
   import scl_pkg::*;
(
   input  wire logic                     clk,         // System clock
   input  wire logic                     rst_b,       // Power-on reset, active low
   input  wire scl_pkg::scl_south_pins_t south_pins,  // South strap pins
   input  wire scl_pkg::scl_north_pins_t north_pins,  // North strap pins
   output      scl_pkg::scl_south_pins_t south_q,     // Held south levels
   output      scl_pkg::scl_north_pins_t north_q,     // Held north levels
   output      logic                     captured_q   // Capture done
);
   `include "scl_params.svh"

   typedef struct packed {
      scl_south_pins_t south;
      scl_north_pins_t north;
      logic            done;
   } scl_latch_st_t;

   scl_latch_st_t st_q;
   scl_latch_st_t st_d;

   // Sample once on the first edge after release; later pin reuse is ignored
   always_comb begin
      st_d = st_q;
      if (!st_q.done) begin
         st_d.south = south_pins;
         st_d.north = north_pins;
         st_d.done  = 1'b1;
      end
   end

   // Reset loads constants only, never the pins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '{south: `SCL_SOUTH_PIN_RST, north: `SCL_NORTH_PIN_RST, done: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign south_q    = st_q.south;
   assign north_q    = st_q.north;
   assign captured_q = st_q.done;
endmodule

/* File: rtl/scl_lock_reg.sv */
// Configuration lock register with its unlocked flag
module scl_lock_reg
   import scl_pkg::*;
(
   input  wire logic       clk,        // System clock
   input  wire logic       rst_b,      // Power-on reset, active low
   input  wire logic       we,         // Write strobe
   input  wire logic [7:0] wdata,      // Write data
   output      logic [7:0] value_q,    // Stored lock byte
   output      logic       unlocked_q  // Key held
);
   `include "scl_params.svh"

   typedef struct packed {
      logic [7:0] value;
      logic       open;
   } scl_lock_st_t;

   scl_lock_st_t st_q;
   scl_lock_st_t st_d;

   // Flag kept as a flop so the decode never sees a compare glitch
   always_comb begin
      st_d = st_q;
      if (we) begin
         st_d.value = wdata;
         st_d.open  = (wdata == `SCL_UNLOCK_KEY);
      end
   end

   // Starts locked
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '{value: `SCL_LOCK_RST, open: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign value_q    = st_q.value;
   assign unlocked_q = st_q.open;
endmodule

/* File: rtl/scl_config_top.sv */
// Index/data port front end with strap status and lock registers
module scl_config_top
   import scl_pkg::*;
#(
   parameter logic [2:0] SOUTH_VERSION = 3'h5,  // Arbitrary value
   parameter logic [3:0] NORTH_VERSION = 4'hA   // Arbitrary value
)
(
   input  wire logic                     clk,           // System clock
   input  wire logic                     rst_b,         // Power-on reset, active low
   input  wire scl_pkg::scl_io_req_t     io_req,        // Host I/O cycle
   input  wire scl_pkg::scl_south_pins_t south_pins,    // South strap pins
   input  wire scl_pkg::scl_north_pins_t north_pins,    // North strap pins
   output      logic [7:0]               io_rdata_q,    // Read data
   output      logic                     io_rvalid_q,   // Read data pulse
   output      logic                     cfg_unlocked,  // Configuration open
   output      scl_pkg::scl_south_pins_t south_straps,  // Held south straps
   output      scl_pkg::scl_north_pins_t north_straps   // Held north straps
);
   import scl_pkg::*;
   `include "scl_params.svh"

   typedef struct packed {
      logic [7:0] index;
      logic [7:0] rdata;
      logic       rvalid;
   } scl_main_st_t;

   scl_main_st_t st_q;
   scl_main_st_t st_d;

   logic [7:0] lock_value;
   logic       straps_done;
   logic       idx_hit;
   logic       data_hit;
   logic       lock_we;

   // Build south register image from held strap levels
   function automatic logic [7:0] south_image(input scl_south_pins_t p,
                                               input logic [2:0]     ver);
      logic [7:0] r;
      r = 8'h00;
      r[`SCL_S_ROM]  = p.rom_width_strap;
      r[`SCL_S_RTC]  = p.rtc_enable_strap;
      r[`SCL_S_KBD]  = p.kbd_ctrl_enable_strap;
      r[`SCL_S_CLK]  = p.clock_ratio_strap;
      r[`SCL_S_VER +: 3] = ver;
      r[`SCL_S_VOLT] = ~p.cpu_voltage_strap;
      return r;
   endfunction

   // Build north register image from held strap levels
   function automatic logic [7:0] north_image(input scl_north_pins_t p,
                                               input logic [3:0]     ver);
      logic [7:0] r;
      r = 8'h00;
      r[`SCL_N_CLK]   = p.clock_ratio_strap;
      r[`SCL_N_CACHE] = p.cache_select_strap;
      r[`SCL_N_PERR]  = p.parity_error_pin_strap;
      r[`SCL_N_VOLT]  = p.north_voltage_strap;
      r[`SCL_N_VER +: 4] = ver;
      return r;
   endfunction

   // Strap capture after power-on reset
   scl_strap_latch u_straps (
      .clk        (clk),
      .rst_b      (rst_b),
      .south_pins (south_pins),
      .north_pins (north_pins),
      .south_q    (south_straps),
      .north_q    (north_straps),
      .captured_q (straps_done)
   );

   // Lock register
   scl_lock_reg u_lock (
      .clk        (clk),
      .rst_b      (rst_b),
      .we         (lock_we),
      .wdata      (io_req.wdata),
      .value_q    (lock_value),
      .unlocked_q (cfg_unlocked)
   );

   // Port decode
   assign idx_hit  = (io_req.addr == `SCL_PORT_INDEX);
   assign data_hit = (io_req.addr == `SCL_PORT_DATA);
   // Lock stays reachable while locked, else nothing could unlock it
   assign lock_we  = io_req.wr && data_hit && (st_q.index == `SCL_IDX_LOCK);

   // Next state: index latch and read data
   always_comb begin
      st_d        = st_q;
      st_d.rvalid = 1'b0;
      // Answer is a one-cycle pulse; the data byte holds until the next read
      if (io_req.wr && idx_hit) begin
         st_d.index = io_req.wdata;
      end
      if (io_req.rd && idx_hit) begin
         st_d.rdata  = st_q.index;
         st_d.rvalid = 1'b1;
      end
      if (io_req.rd && data_hit) begin
         st_d.rvalid = 1'b1;
         case (st_q.index)
            `SCL_IDX_LOCK: begin
               st_d.rdata = lock_value;
            end
            `SCL_IDX_SOUTH: begin
               // Hidden while locked
               st_d.rdata = cfg_unlocked ?
                            south_image(south_straps, SOUTH_VERSION) :
                            `SCL_FLOAT_DATA;
            end
            `SCL_IDX_NORTH: begin
               st_d.rdata = cfg_unlocked ?
                            north_image(north_straps, NORTH_VERSION) :
                            `SCL_FLOAT_DATA;
            end
            default: begin
               st_d.rdata = `SCL_FLOAT_DATA;
            end
         endcase
      end
      // Writes to the status indices are dropped: read-only
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '{index: `SCL_INDEX_RST, rdata: 8'h00, rvalid: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign io_rdata_q  = st_q.rdata;
   assign io_rvalid_q = st_q.rvalid;

   // Checks on the registered read path, lock writes and held straps
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic rd_data;
   assign rd_data = io_req.rd && data_hit;

   // Qualified register reads, shared by the per-field and lock-byte checks below
   logic rd_south;
   logic rd_north;
   logic rd_lock;
   assign rd_south = rd_data && cfg_unlocked && (st_q.index == `SCL_IDX_SOUTH);
   assign rd_north = rd_data && cfg_unlocked && (st_q.index == `SCL_IDX_NORTH);
   assign rd_lock  = rd_data && (st_q.index == `SCL_IDX_LOCK);

   property p_rom_bit;
      rd_data && cfg_unlocked && st_q.index == `SCL_IDX_SOUTH
      |=> io_rdata_q[`SCL_S_ROM] == $past(south_straps.rom_width_strap)
          && io_rdata_q[`SCL_S_RTC] == $past(south_straps.rtc_enable_strap);
   endproperty
   a_rom_bit: assert property (p_rom_bit)
      else $error("south ROM or RTC bit wrong");

   property p_kbd_clk;
      rd_data && cfg_unlocked && st_q.index == `SCL_IDX_SOUTH
      |=> io_rdata_q[`SCL_S_KBD] == $past(south_straps.kbd_ctrl_enable_strap)
          && io_rdata_q[`SCL_S_CLK] == $past(south_straps.clock_ratio_strap);
   endproperty
   a_kbd_clk: assert property (p_kbd_clk)
      else $error("south keyboard or clock bit wrong");

   property p_south_volt;
      rd_data && cfg_unlocked && st_q.index == `SCL_IDX_SOUTH
      |=> io_rdata_q[`SCL_S_VOLT] != $past(south_straps.cpu_voltage_strap)
          && io_rdata_q[6:4] == SOUTH_VERSION;
   endproperty
   a_south_volt: assert property (p_south_volt)
      else $error("south voltage or version wrong");

   property p_north_bits;
      rd_data && cfg_unlocked && st_q.index == `SCL_IDX_NORTH
      |=> io_rdata_q[3:0] == $past(north_straps)
          && io_rdata_q[7:4] == NORTH_VERSION;
   endproperty
   a_north_bits: assert property (p_north_bits)
      else $error("north register image wrong");

   property p_lock_write;
      io_req.wr && data_hit && st_q.index == `SCL_IDX_LOCK
      |=> cfg_unlocked == ($past(io_req.wdata) == `SCL_UNLOCK_KEY)
          && lock_value == $past(io_req.wdata);
   endproperty
   a_lock_write: assert property (p_lock_write)
      else $error("lock flag not following key");

   property p_locked_hidden;
      rd_data && !cfg_unlocked && st_q.index != `SCL_IDX_LOCK
      |=> io_rdata_q == `SCL_FLOAT_DATA;
   endproperty
   a_locked_hidden: assert property (p_locked_hidden)
      else $error("locked register visible");

   property p_index_echo;
      io_req.wr && idx_hit ##1 io_req.rd && idx_hit && !io_req.wr
      |=> io_rdata_q == $past(io_req.wdata, 2) && io_rvalid_q;
   endproperty
   a_index_echo: assert property (p_index_echo)
      else $error("index port not holding value");

   property p_straps_hold;
      straps_done && $past(straps_done)
      |-> $stable(south_straps) && $stable(north_straps);
   endproperty
   a_straps_hold: assert property (p_straps_hold)
      else $error("strap levels changed after capture");

   property p_status_ro;
      io_req.wr && data_hit && st_q.index != `SCL_IDX_LOCK
      |=> $stable(lock_value) && $stable(cfg_unlocked);
   endproperty
   a_status_ro: assert property (p_status_ro)
      else $error("write to read-only index had an effect");

   property p_rvalid_once;
      io_req.rd && (data_hit || idx_hit) |=> io_rvalid_q;
   endproperty
   a_rvalid_once: assert property (p_rvalid_once)
      else $error("read not answered next cycle");

   // South image, one field per check so a failure names its field
   property p_rtc_bit;
      rd_south |=> io_rdata_q[`SCL_S_RTC] == $past(south_straps.rtc_enable_strap);
   endproperty
   a_rtc_bit: assert property (p_rtc_bit)
      else $error("south RTC bit wrong");

   property p_clk_bit;
      rd_south |=> io_rdata_q[`SCL_S_CLK] == $past(south_straps.clock_ratio_strap);
   endproperty
   a_clk_bit: assert property (p_clk_bit)
      else $error("south clock ratio bit wrong");

   property p_south_ver;
      rd_south |=> io_rdata_q[`SCL_S_VER +: 3] == SOUTH_VERSION;
   endproperty
   a_south_ver: assert property (p_south_ver)
      else $error("south version field wrong");

   // North image fields
   property p_north_clk;
      rd_north |=> io_rdata_q[`SCL_N_CLK] == $past(north_straps.clock_ratio_strap);
   endproperty
   a_north_clk: assert property (p_north_clk)
      else $error("north clock ratio bit wrong");

   property p_north_cache;
      rd_north |=> io_rdata_q[`SCL_N_CACHE] == $past(north_straps.cache_select_strap);
   endproperty
   a_north_cache: assert property (p_north_cache)
      else $error("north cache select bit wrong");

   property p_north_perr;
      rd_north |=> io_rdata_q[`SCL_N_PERR] == $past(north_straps.parity_error_pin_strap);
   endproperty
   a_north_perr: assert property (p_north_perr)
      else $error("north parity pin bit wrong");

   property p_north_volt;
      rd_north |=> io_rdata_q[`SCL_N_VOLT] == $past(north_straps.north_voltage_strap);
   endproperty
   a_north_volt: assert property (p_north_volt)
      else $error("north voltage bit wrong");

   property p_north_ver;
      rd_north |=> io_rdata_q[`SCL_N_VER +: 4] == NORTH_VERSION;
   endproperty
   a_north_ver: assert property (p_north_ver)
      else $error("north version field wrong");

   // Lock byte: readable at any time, cleared by reset
   property p_lock_read;
      rd_lock |=> io_rdata_q == $past(lock_value) && io_rvalid_q;
   endproperty
   a_lock_read: assert property (p_lock_read)
      else $error("lock byte not returned on read");

   // First edge after release still shows the reset lock state
   property p_lock_reset;
      !straps_done |-> !cfg_unlocked && (lock_value == `SCL_LOCK_RST);
   endproperty
   a_lock_reset: assert property (p_lock_reset)
      else $error("lock not cleared by reset");

   // Port protocol: unmapped indices, index persistence, answer pulse
   property p_unknown_index;
      rd_data && !(st_q.index inside {`SCL_IDX_SOUTH, `SCL_IDX_NORTH, `SCL_IDX_LOCK})
      |=> io_rdata_q == `SCL_FLOAT_DATA;
   endproperty
   a_unknown_index: assert property (p_unknown_index)
      else $error("unmapped index not read as float value");

   property p_index_hold;
      !(io_req.wr && idx_hit) |=> $stable(st_q.index);
   endproperty
   a_index_hold: assert property (p_index_hold)
      else $error("index changed without an index write");

   property p_rvalid_idle;
      !(io_req.rd && (data_hit || idx_hit)) |=> !io_rvalid_q;
   endproperty
   a_rvalid_idle: assert property (p_rvalid_idle)
      else $error("read pulse without a read");

   // Capture takes the pin levels present at the first edge after release
   property p_strap_capture;
      !straps_done
      |=> (south_straps == $past(south_pins)) && (north_straps == $past(north_pins));
   endproperty
   a_strap_capture: assert property (p_strap_capture)
      else $error("strap levels not captured from pins");

   // Main scenarios
   c_unlock: cover property (
      io_req.wr && idx_hit && io_req.wdata == `SCL_IDX_LOCK
      ##1 io_req.wr && data_hit && io_req.wdata == `SCL_UNLOCK_KEY);
   c_read_south: cover property (
      rd_data && cfg_unlocked && st_q.index == `SCL_IDX_SOUTH);
   c_read_north: cover property (
      rd_data && cfg_unlocked && st_q.index == `SCL_IDX_NORTH);
   c_relock: cover property (cfg_unlocked ##1 !cfg_unlocked);
   c_index_echo: cover property (
      io_req.wr && idx_hit ##1 io_req.rd && idx_hit);
endmodule

/* File: tb/scl_host_model.sv */
// Host model issuing index/data I/O cycles toward the block
module scl_host_model
   import scl_pkg::*;
(
   input  wire logic                 clk,         // System clock
   output      scl_pkg::scl_io_req_t io_req,      // Host I/O cycle
   input  wire logic [7:0]           io_rdata_q,  // Read data
   input  wire logic                 io_rvalid_q  // Read data pulse
);
   timeunit 1ns;
   timeprecision 1ps;
`include "scl_params.svh"

   // Bus starts idle
   initial begin
      io_req = '0;
   end

   // Released bus shows inverted address and data so a stale value never matches
   task automatic idle();
      @(negedge clk);
      io_req.wr    = 1'b0;
      io_req.rd    = 1'b0;
      io_req.addr  = ~io_req.addr;
      io_req.wdata = ~io_req.wdata;
   endtask

   // One write, held until the sampling edge
   task automatic wr_port(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      io_req.wr    = 1'b1;
      io_req.rd    = 1'b0;
      io_req.addr  = a;
      io_req.wdata = d;
      @(posedge clk);
   endtask

   // One read; data is taken in the cycle after the sampling edge
   task automatic rd_port(input logic [15:0] a, output logic [7:0] d, output logic v);
      @(negedge clk);
      io_req.wr    = 1'b0;
      io_req.rd    = 1'b1;
      io_req.addr  = a;
      io_req.wdata = ~io_req.wdata;
      @(posedge clk);
      @(negedge clk);
      io_req.rd   = 1'b0;
      io_req.addr = ~a;
      v = io_rvalid_q;
      d = io_rdata_q;
   endtask

   // Index first, then data; only the lock byte is meant to change
   task automatic cfg_write(input logic [7:0] idx, input logic [7:0] d);
      wr_port(`SCL_PORT_INDEX, idx);
      wr_port(`SCL_PORT_DATA, d);
   endtask

   task automatic cfg_read(input logic [7:0] idx, output logic [7:0] d, output logic v);
      wr_port(`SCL_PORT_INDEX, idx);
      rd_port(`SCL_PORT_DATA, d, v);
   endtask

   // Unlock sequence: lock index, then the key
   task automatic unlock();
      cfg_write(`SCL_IDX_LOCK, `SCL_UNLOCK_KEY);
   endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the strap status and lock block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import scl_pkg::*;
`include "scl_params.svh"

   localparam logic [2:0] SV = 3'h5;  // Arbitrary version code
   localparam logic [3:0] NV = 4'hA;  // Arbitrary version code

   logic            clk;
   logic            rst_b;
   scl_io_req_t     io_req;
   scl_south_pins_t south_pins;
   scl_north_pins_t north_pins;
   logic [7:0]      io_rdata_q;
   logic            io_rvalid_q;
   logic            cfg_unlocked;
   scl_south_pins_t south_straps;
   scl_north_pins_t north_straps;
   int              bad_count;
   int              samples_checked;
   logic [7:0]      rd;
   logic            rv;

   scl_config_top #(.SOUTH_VERSION(SV), .NORTH_VERSION(NV)) scl_config_top_inst (
      .clk(clk), .rst_b(rst_b), .io_req(io_req), .south_pins(south_pins),
      .north_pins(north_pins), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
      .cfg_unlocked(cfg_unlocked), .south_straps(south_straps),
      .north_straps(north_straps));

   scl_host_model scl_host_model_inst (
      .clk(clk), .io_req(io_req), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q));

   // 100 MHz clock
   always #5 clk = ~clk;

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Reset with given strap levels, released off the clock edge
   task automatic do_reset(input logic [4:0] s, input logic [3:0] n);
      @(negedge clk);
      rst_b      = 1'b0;
      south_pins = s;
      north_pins = n;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
   endtask

   // Locked after reset: lock byte clear, strap registers hidden
   task automatic locked_after_reset(input logic [4:0] s, input logic [3:0] n);
      @(negedge clk);
      check("south_straps", 8'(south_straps), 8'(s));
      check("north_straps", 8'(north_straps), 8'(n));
      check("unlocked_rst", 8'(cfg_unlocked), 8'h00);
      scl_host_model_inst.cfg_read(`SCL_IDX_LOCK, rd, rv);
      check("lock_rst", rd, 8'h00);
      check("lock_rst_valid", 8'(rv), 8'h01);
      scl_host_model_inst.cfg_read(`SCL_IDX_SOUTH, rd, rv);
      check("south_locked", rd, `SCL_FLOAT_DATA);
      scl_host_model_inst.cfg_read(`SCL_IDX_NORTH, rd, rv);
      check("north_locked", rd, `SCL_FLOAT_DATA);
   endtask

   // Unlock, move the pins, read both strap images, try to overwrite them
   task automatic unlocked_reads(input logic [4:0] s, input logic [3:0] n);
      logic [7:0] s_img;
      logic [7:0] n_img;
      s_img = {~s[4], SV, s[3:0]};
      n_img = {NV, n};
      scl_host_model_inst.unlock();
      scl_host_model_inst.idle();
      check("unlocked", 8'(cfg_unlocked), 8'h01);
      scl_host_model_inst.cfg_read(`SCL_IDX_LOCK, rd, rv);
      check("lock_key", rd, `SCL_UNLOCK_KEY);
      south_pins = ~s;
      north_pins = ~n;
      scl_host_model_inst.cfg_read(`SCL_IDX_SOUTH, rd, rv);
      check("south_img", rd, s_img);
      scl_host_model_inst.cfg_read(`SCL_IDX_NORTH, rd, rv);
      check("north_img", rd, n_img);
      scl_host_model_inst.cfg_read(8'h10, rd, rv);
      check("unmapped", rd, `SCL_FLOAT_DATA);
      scl_host_model_inst.cfg_write(`SCL_IDX_SOUTH, ~s_img);
      scl_host_model_inst.cfg_write(`SCL_IDX_NORTH, ~n_img);
      scl_host_model_inst.cfg_read(`SCL_IDX_SOUTH, rd, rv);
      check("south_ro", rd, s_img);
      scl_host_model_inst.cfg_read(`SCL_IDX_NORTH, rd, rv);
      check("north_ro", rd, n_img);
   endtask

   // Any non-key byte locks again; index port and one stray port
   task automatic relock();
      scl_host_model_inst.cfg_write(`SCL_IDX_LOCK, 8'hC4);
      scl_host_model_inst.idle();
      check("relocked", 8'(cfg_unlocked), 8'h00);
      scl_host_model_inst.cfg_read(`SCL_IDX_LOCK, rd, rv);
      check("lock_rw", rd, 8'hC4);
      scl_host_model_inst.cfg_read(`SCL_IDX_SOUTH, rd, rv);
      check("south_relocked", rd, `SCL_FLOAT_DATA);
      scl_host_model_inst.wr_port(`SCL_PORT_INDEX, `SCL_IDX_NORTH);
      scl_host_model_inst.rd_port(`SCL_PORT_INDEX, rd, rv);
      check("index_port", rd, `SCL_IDX_NORTH);
      check("index_port_valid", 8'(rv), 8'h01);
      scl_host_model_inst.rd_port(16'h0024, rd, rv);
      check("stray_port", 8'(rv), 8'h00);
   endtask

   task automatic run_all(input logic [4:0] s, input logic [3:0] n);
      locked_after_reset(s, n);
      unlocked_reads(s, n);
      relock();
   endtask

   // Main sequence: two resets with complementary strap levels
   initial begin
      clk             = 1'b0;
      rst_b           = 1'b0;
      south_pins      = '0;
      north_pins      = '0;
      bad_count       = 0;
      samples_checked = 0;
      do_reset(5'h0A, 4'h5);
      run_all(5'h0A, 4'h5);
      do_reset(5'h15, 4'hA);
      run_all(5'h15, 4'hA);
      wrap_up();
   end

   // Watchdog: the whole run needs only about a hundred cycles
   initial begin
      #20000;
      bad_count++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule
